// ### design/hbcs_sequencer.sv
// boot and mode sequencer of the hub: standby through normal operation
`timescale 1ns/1ps
// Behaviour
// - reset low: standby, pins released, pll halted
// - standby aborts work, ports off, defaults
// - reset high: hub mode runs boot stages
// - flash probe resets logic, pll, defaults
// - match 2DFU at 0x3FFFA, run from 0
// - signature mismatch goes to rom defaults
// - no flash strap skips to rom defaults
// - single, dual, quad lanes; modes 0, 3
// - rom stage loads configuration defaults
// - strap stage samples straps, overriding rom
// - configs 1,2,3,5 go to pull-up probe
// - both pull-ups: slave, host configuration
// - host configuration waits without timeout
// - attach commands 0xAA55/0xAA56 end configuration; legacy mode ends on a write to 0xFF
// - merge rom, host and otp data
// - connect sets attach and superspeed enable
// - normal operation until mode changes
// - reset low from any stage: standby
// - soft disconnect returns to connect stage
module hbcs_sequencer
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic flash_mode_strap,
   input wire logic [1:0] flash_lanes,
   input wire logic flash_cpol_mode3,
   input wire logic flash_byte_valid,
   input wire logic [7:0] flash_byte,
   input wire logic [2:0] config_select_straps,
   input wire logic [3:0] port_disable_plus_straps,
   input wire logic [3:0] port_disable_minus_straps,
   input wire logic nonremovable_strap,
   input wire logic charging_enable_strap,
   input wire logic sb_clk_pullup,
   input wire logic sb_data_pullup,
   input wire logic sb_legacy_mode,
   input wire logic sb_write_valid,
   input wire logic [7:0] sb_write_reg,
   input wire logic sb_cmd_valid,
   input wire logic [15:0] sb_cmd,
   input wire logic [7:0] otp_cfg,
   input wire logic [7:0] host_cfg,
   input wire logic soft_disconnect,
   output logic flash_read_req,
   output logic [17:0] flash_addr,
   output logic [1:0] flash_lanes_used,
   output logic flash_spi_mode3,
   output logic flash_exec,
   output logic pll_run,
   output logic pins_release_n,
   output logic sb_slave_en,
   output logic [3:0] port_enable_plus,
   output logic [3:0] port_enable_minus,
   output logic nonremovable,
   output logic charging_en,
   output logic [7:0] merged_cfg,
   output logic usb_attach_bit,
   output logic superspeed_enable_bit,
   output logic [3:0] boot_stage
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   typedef struct packed
   {
      hbcs_pkg::hbcs_state_t stage;
      logic [2:0] cnt;
      logic sig_started;
      logic flash_exec;
      logic sb_slave;
      logic [3:0] pe_plus;
      logic [3:0] pe_minus;
      logic nonrem;
      logic chg;
      logic [7:0] cfg;
      logic attach;
      logic ss_en;
      logic [1:0] lanes;
      logic mode3;
   } hbcs_state_s_t;
   hbcs_state_s_t st_ff;
   hbcs_state_s_t nxt_st;

   logic run_sync; // synchronised reset release
   logic [19:0] pin_sync; // synchronised pin inputs
   logic sig_start; // starts signature compare
   logic sig_done; // compare finished
   logic sig_match; // compare result
   logic cfg_probe; // strap selects pull-up probe
   logic cfg_end; // host ended configuration

   ////////////////////////////////////////////////////////////////////////////
   // synchronisers
   // reset release into the core clock
   hbcs_sync #(.WIDTH(1)) u_rst_sync
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in(1'b1),
      .sync_out(run_sync)
   );

   // straps, pull-ups and soft disconnect pins
   hbcs_sync #(.WIDTH(20)) u_pin_sync
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in({flash_mode_strap, flash_lanes, flash_cpol_mode3, nonremovable_strap, charging_enable_strap,
                 soft_disconnect, config_select_straps, port_disable_plus_straps, port_disable_minus_straps,
                 sb_clk_pullup, sb_data_pullup}),
      .sync_out(pin_sync)
   );

   logic [2:0] cfg_sel_s;
   logic [3:0] dis_p_s;
   logic [3:0] dis_m_s;
   logic flash_mode_s, mode3_s, nonrem_s, chg_s, disc_s; // synchronised single-bit straps and disconnect
   logic [1:0] lanes_s; // synchronised lane strap
   assign {flash_mode_s, lanes_s, mode3_s, nonrem_s, chg_s, disc_s, cfg_sel_s, dis_p_s, dis_m_s} = pin_sync[19:2];

   ////////////////////////////////////////////////////////////////////////////
   // signature checker
   hbcs_sig_check u_sig
   (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .start(sig_start),
      .byte_valid(flash_byte_valid),
      .byte_data(flash_byte),
      .done(sig_done),
      .match(sig_match)
   );

   ////////////////////////////////////////////////////////////////////////////
   // decodes
   assign cfg_probe = (cfg_sel_s == hbcs_pkg::CFG_SEL_1) || (cfg_sel_s == hbcs_pkg::CFG_SEL_2) ||
                      (cfg_sel_s == hbcs_pkg::CFG_SEL_3) || (cfg_sel_s == hbcs_pkg::CFG_SEL_5);
   // legacy ends on reg write, otherwise on attach command
   assign cfg_end = sb_legacy_mode ? (sb_write_valid && (sb_write_reg == hbcs_pkg::LEGACY_END_REG)) :
      (sb_cmd_valid && ((sb_cmd == hbcs_pkg::CMD_ATTACH) || (sb_cmd == hbcs_pkg::CMD_ATTACH_SB)));

   assign sig_start = (st_ff.stage == hbcs_pkg::ST_FLASH_PROBE) && !st_ff.sig_started;

   ////////////////////////////////////////////////////////////////////////////
   // next-state logic
   always_comb
   begin
      nxt_st = st_ff;
      case (st_ff.stage)
         // standby: wait for the synchronised release
         hbcs_pkg::ST_STANDBY:
         begin
            if (run_sync)
            begin
               nxt_st.stage = hbcs_pkg::ST_FLASH_PROBE;
               nxt_st.sig_started = 1'b0;
            end
         end
         // flash probe: straps decide, then signature decides
         hbcs_pkg::ST_FLASH_PROBE:
         begin
            nxt_st.lanes = (lanes_s == 2'h3) ? hbcs_pkg::LANES_QUAD : lanes_s;
            nxt_st.mode3 = mode3_s;
            if (!flash_mode_s)
               nxt_st.stage = hbcs_pkg::ST_ROM_DEFAULTS;
            else if (!st_ff.sig_started)
               nxt_st.sig_started = 1'b1;
            else if (sig_done)
            begin
               if (sig_match)
               begin
                  nxt_st.flash_exec = 1'b1;
                  nxt_st.stage = hbcs_pkg::ST_FLASH_RUN;
               end
               else
                  nxt_st.stage = hbcs_pkg::ST_ROM_DEFAULTS;
            end
            nxt_st.cnt = 3'h0;
         end
         // external code owns the hub until reset
         hbcs_pkg::ST_FLASH_RUN: nxt_st.stage = hbcs_pkg::ST_FLASH_RUN;
         // rom defaults load over a few cycles
         hbcs_pkg::ST_ROM_DEFAULTS:
         begin
            nxt_st.cfg = hbcs_pkg::CFG_RST;
            nxt_st.pe_plus = 4'hF;
            nxt_st.pe_minus = 4'hF;
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == 3'(hbcs_pkg::ROM_LOAD_CYCLES - 1))
            begin
               nxt_st.stage = hbcs_pkg::ST_STRAP;
               nxt_st.cnt = 3'h0;
            end
         end
         // straps override rom values
         hbcs_pkg::ST_STRAP:
         begin
            nxt_st.pe_plus = ~dis_p_s;
            nxt_st.pe_minus = ~dis_m_s;
            nxt_st.nonrem = nonrem_s;
            nxt_st.chg = chg_s;
            nxt_st.stage = cfg_probe ? hbcs_pkg::ST_PULLUP_PROBE : hbcs_pkg::ST_MERGE;
         end
         // both pull-ups needed to act as sideband slave
         hbcs_pkg::ST_PULLUP_PROBE:
         begin
            if (pin_sync[1] && pin_sync[0])
            begin
               nxt_st.sb_slave = 1'b1;
               nxt_st.stage = hbcs_pkg::ST_HOST_CFG;
            end
            else
               nxt_st.stage = hbcs_pkg::ST_MERGE;
         end
         // host may alter settings; no timeout
         hbcs_pkg::ST_HOST_CFG:
         begin
            nxt_st.cfg = host_cfg;
            if (cfg_end)
               nxt_st.stage = hbcs_pkg::ST_MERGE;
         end
         // merge rom, host and otp data
         hbcs_pkg::ST_MERGE:
         begin
            nxt_st.cnt = st_ff.cnt + 3'h1;
            if (st_ff.cnt == 3'(hbcs_pkg::MERGE_CYCLES - 1))
            begin
               nxt_st.cfg = st_ff.cfg | otp_cfg;
               nxt_st.stage = hbcs_pkg::ST_CONNECT;
               nxt_st.cnt = 3'h0;
            end
         end
         // attach; hold here during soft disconnect
         hbcs_pkg::ST_CONNECT:
         begin
            if (!disc_s)
            begin
               nxt_st.attach = 1'b1;
               nxt_st.ss_en = 1'b1;
               nxt_st.stage = hbcs_pkg::ST_NORMAL;
            end
            else
            begin
               nxt_st.attach = 1'b0;
               nxt_st.ss_en = 1'b0;
            end
         end
         // normal operation under upstream host
         hbcs_pkg::ST_NORMAL:
         begin
            if (disc_s)
            begin
               nxt_st.stage = hbcs_pkg::ST_CONNECT;
               nxt_st.attach = 1'b0;
               nxt_st.ss_en = 1'b0;
            end
         end
         default: nxt_st.stage = hbcs_pkg::ST_STANDBY;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // state register; reset low wipes everything to standby
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end

   ////////////////////////////////////////////////////////////////////////////
   // outputs
   assign boot_stage = st_ff.stage;
   assign pll_run = (st_ff.stage != hbcs_pkg::ST_STANDBY);
   assign pins_release_n = (st_ff.stage == hbcs_pkg::ST_STANDBY);
   assign flash_read_req = (st_ff.stage == hbcs_pkg::ST_FLASH_PROBE) && st_ff.sig_started;
   assign flash_addr = st_ff.flash_exec ? hbcs_pkg::EXEC_ADDR : hbcs_pkg::SIG_ADDR;
   assign flash_lanes_used = st_ff.lanes;
   assign flash_spi_mode3 = st_ff.mode3;
   assign flash_exec = st_ff.flash_exec;
   assign sb_slave_en = st_ff.sb_slave;
   assign port_enable_plus = st_ff.pe_plus;
   assign port_enable_minus = st_ff.pe_minus;
   assign nonremovable = st_ff.nonrem;
   assign charging_en = st_ff.chg;
   assign merged_cfg = st_ff.cfg;
   assign usb_attach_bit = st_ff.attach;
   assign superspeed_enable_bit = st_ff.ss_en;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   chk_strap_to_probe: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_STRAP && cfg_probe) |=> (st_ff.stage == hbcs_pkg::ST_PULLUP_PROBE))
      else $error("strap config did not enter pull-up probe");
   chk_no_flash_skip: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_FLASH_PROBE && !flash_mode_s) |=>
      (st_ff.stage == hbcs_pkg::ST_ROM_DEFAULTS))
      else $error("missing flash strap did not skip to rom");
   chk_rom_to_strap: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_ff.stage == hbcs_pkg::ST_ROM_DEFAULTS) |-> ##4 (st_ff.stage == hbcs_pkg::ST_STRAP))
      else $error("rom stage length wrong");
   chk_host_end: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_HOST_CFG && cfg_end) |=> (st_ff.stage == hbcs_pkg::ST_MERGE))
      else $error("end of configuration not honoured");
   chk_host_wait: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_HOST_CFG && !cfg_end) |=> (st_ff.stage == hbcs_pkg::ST_HOST_CFG))
      else $error("host configuration left without end");
   chk_pullup_both: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_PULLUP_PROBE) |=>
      (sb_slave_en == (st_ff.stage == hbcs_pkg::ST_HOST_CFG)))
      else $error("pull-up probe result wrong");
   chk_attach_bits: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_NORMAL) |-> (usb_attach_bit && superspeed_enable_bit))
      else $error("normal without attach bits");
   chk_soft_disc: assert property (@(posedge clk_sys) disable iff (!rst_n)
      (st_ff.stage == hbcs_pkg::ST_NORMAL && disc_s) |=>
      (st_ff.stage == hbcs_pkg::ST_CONNECT && !usb_attach_bit))
      else $error("soft disconnect not returning to connect");
   chk_merge_len: assert property (@(posedge clk_sys) disable iff (!rst_n)
      $rose(st_ff.stage == hbcs_pkg::ST_MERGE) |-> ##2 (st_ff.stage == hbcs_pkg::ST_CONNECT))
      else $error("merge stage length wrong");
   cov_flash_boot: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st_ff.stage == hbcs_pkg::ST_FLASH_RUN);
   cov_host_cfg: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st_ff.stage == hbcs_pkg::ST_HOST_CFG ##1 st_ff.stage == hbcs_pkg::ST_MERGE);
   cov_normal: cover property (@(posedge clk_sys) disable iff (!rst_n)
      st_ff.stage == hbcs_pkg::ST_NORMAL);
endmodule

// ### design/hbcs_pkg.sv
// package of constants and state codes for the hub boot configuration sequencer
package hbcs_pkg;
   // flash signature location and expected characters
   localparam logic [17:0] SIG_ADDR = 18'h3FFFA; // first signature byte
   localparam logic [17:0] EXEC_ADDR = 18'h00000; // external execution start
   localparam logic [31:0] SIG_WORD = 32'h32444655; // ascii 2 D F U
   localparam logic [2:0] SIG_LEN = 3'h4; // bytes compared
   // flash access modes
   localparam logic [1:0] LANES_SINGLE = 2'h0;
   localparam logic [1:0] LANES_DUAL = 2'h1;
   localparam logic [1:0] LANES_QUAD = 2'h2;
   // sideband end-of-configuration codes
   localparam logic [7:0] LEGACY_END_REG = 8'hFF;
   localparam logic [15:0] CMD_ATTACH = 16'hAA55;
   localparam logic [15:0] CMD_ATTACH_SB = 16'hAA56;
   // configuration strap codes that need the pull-up probe
   localparam logic [2:0] CFG_SEL_1 = 3'h1;
   localparam logic [2:0] CFG_SEL_2 = 3'h2;
   localparam logic [2:0] CFG_SEL_3 = 3'h3;
   localparam logic [2:0] CFG_SEL_5 = 3'h5;
   // reset values
   localparam logic [3:0] PORT_EN_RST = 4'h0;
   localparam logic [7:0] CFG_RST = 8'h00;
   // cycles spent in the rom load and merge stages
   localparam int ROM_LOAD_CYCLES = 4;
   localparam int MERGE_CYCLES = 2;
   // boot stages
   typedef enum logic [3:0]
   {
      ST_STANDBY = 4'h0,
      ST_FLASH_PROBE = 4'h1,
      ST_ROM_DEFAULTS = 4'h2,
      ST_STRAP = 4'h3,
      ST_PULLUP_PROBE = 4'h4,
      ST_HOST_CFG = 4'h5,
      ST_MERGE = 4'h6,
      ST_CONNECT = 4'h7,
      ST_NORMAL = 4'h8,
      ST_FLASH_RUN = 4'h9
   } hbcs_state_t;
endpackage

// ### design/hbcs_sync.sv
// two-stage synchroniser for pin inputs and the reset release
`timescale 1ns/1ps
module hbcs_sync
#(
   parameter int WIDTH = 1
)
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   // both stages as one struct
   typedef struct packed
   {
      logic [WIDTH-1:0] meta_ff;
      logic [WIDTH-1:0] sync_ff;
   } hbcs_sync_t;
   hbcs_sync_t st_ff;
   hbcs_sync_t nxt_st;

   // elaboration check: a zero-width synchroniser cannot be built
   if (WIDTH < 1)
   begin
      $error("hbcs_sync width must be at least one");
   end

   // first stage feeds only the second stage
   always_comb
   begin
      nxt_st.meta_ff = async_in;
      nxt_st.sync_ff = st_ff.meta_ff;
   end

   // registers clear to zero under reset
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign sync_out = st_ff.sync_ff;
endmodule

// ### design/hbcs_sig_check.sv
// compares flash bytes against the boot signature one byte at a time
`timescale 1ns/1ps
module hbcs_sig_check
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic start,
   input wire logic byte_valid,
   input wire logic [7:0] byte_data,
   output logic done,
   output logic match
);
   // compare state
   typedef struct packed
   {
      logic busy_ff;
      logic [2:0] idx_ff;
      logic ok_ff;
      logic done_ff;
   } hbcs_sig_t;
   hbcs_sig_t st_ff;
   hbcs_sig_t nxt_st;
   logic [7:0] expect_byte;

   // expected byte picked from the signature word, first char highest
   always_comb
   begin
      case (st_ff.idx_ff)
         3'h0: expect_byte = hbcs_pkg::SIG_WORD[31:24];
         3'h1: expect_byte = hbcs_pkg::SIG_WORD[23:16];
         3'h2: expect_byte = hbcs_pkg::SIG_WORD[15:8];
         3'h3: expect_byte = hbcs_pkg::SIG_WORD[7:0];
         default: expect_byte = 8'h00;
      endcase
   end

   // walk the four bytes, any mismatch clears ok
   always_comb
   begin
      nxt_st = st_ff;
      nxt_st.done_ff = 1'b0;
      if (start)
      begin
         nxt_st.busy_ff = 1'b1;
         nxt_st.idx_ff = 3'h0;
         nxt_st.ok_ff = 1'b1;
      end
      else if (st_ff.busy_ff && byte_valid)
      begin
         if (byte_data != expect_byte)
         begin
            nxt_st.ok_ff = 1'b0;
         end
         if (st_ff.idx_ff == hbcs_pkg::SIG_LEN - 3'h1)
         begin
            nxt_st.busy_ff = 1'b0;
            nxt_st.done_ff = 1'b1;
         end
         nxt_st.idx_ff = st_ff.idx_ff + 3'h1;
      end
   end

   // state register
   always_ff @(posedge clk_sys or negedge rst_n)
   begin
      if (!rst_n)
      begin
         st_ff <= '0;
      end
      else
      begin
         st_ff <= nxt_st;
      end
   end

   assign done = st_ff.done_ff;
   assign match = st_ff.ok_ff;
endmodule

// ### tb/hbcs_partner.sv
// model of the boot flash and of the sideband configuration master
`timescale 1ns/1ps
module hbcs_partner
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic flash_read_req,
   input wire logic sig_ok,
   input wire logic [3:0] byte_gap,
   input wire logic sb_slave_en,
   input wire logic sb_legacy_mode,
   input wire logic [1:0] end_kind,
   output logic flash_byte_valid,
   output logic [7:0] flash_byte,
   output logic sb_write_valid,
   output logic [7:0] sb_write_reg,
   output logic sb_cmd_valid,
   output logic [15:0] sb_cmd
);
   logic [31:0] sig_word; // bytes handed out, first byte on top
   int i;
   ////////////////////////////////////////////////////////////////
   // one end-of-configuration pulse; a bad one must be ignored
   task automatic send(input logic good);
      if (sb_legacy_mode)
      begin
         sb_write_reg = good ? hbcs_pkg::LEGACY_END_REG : 8'hFE;
         sb_write_valid = 1'b1;
         @(negedge clk_sys);
         sb_write_valid = 1'b0;
         sb_write_reg = ~sb_write_reg; // released bus shows no stale value
      end
      else
      begin
         sb_cmd = !good ? 16'hAA57 : (end_kind == 2'h2 ? hbcs_pkg::CMD_ATTACH_SB : hbcs_pkg::CMD_ATTACH);
         sb_cmd_valid = 1'b1;
         @(negedge clk_sys);
         sb_cmd_valid = 1'b0;
         sb_cmd = ~sb_cmd;
      end
   endtask
   ////////////////////////////////////////////////////////////////
   // flash: four signature bytes per fetch, with a gap for a slow part
   initial
   begin
      flash_byte_valid = 1'b0;
      flash_byte = 8'h00;
      forever
      begin
         @(negedge clk_sys);
         if (rst_n && flash_read_req)
         begin
            // a bad image differs in the last byte only
            sig_word = sig_ok ? hbcs_pkg::SIG_WORD : (hbcs_pkg::SIG_WORD ^ 32'h00000003);
            for (i = 3; i >= 0; i--)
            begin
               // back-to-back bytes keep valid high; a gap drops it first
               if (byte_gap != 4'h0)
               begin
                  flash_byte_valid = 1'b0;
                  flash_byte = ~flash_byte;
                  repeat (byte_gap) @(negedge clk_sys);
               end
               flash_byte_valid = 1'b1;
               flash_byte = sig_word[i*8 +: 8];
               @(negedge clk_sys);
            end
            flash_byte_valid = 1'b0;
            flash_byte = ~flash_byte;
            wait (!flash_read_req || !rst_n);
         end
      end
   end
   ////////////////////////////////////////////////////////////////
   // master: a wrong end code first, then the right one
   initial
   begin
      sb_write_valid = 1'b0;
      sb_write_reg = 8'h00;
      sb_cmd_valid = 1'b0;
      sb_cmd = 16'h0000;
      forever
      begin
         @(negedge clk_sys);
         if (rst_n && sb_slave_en)
         begin
            repeat (3) @(negedge clk_sys);
            send(1'b0);
            repeat (6) @(negedge clk_sys);
            send(1'b1);
            wait (!sb_slave_en || !rst_n);
         end
      end
   end
endmodule

// ### tb/hub_boot_config_sequencer_tb.sv
// self-checking bench of the hub boot configuration sequencer
`timescale 1ns/1ps
module hub_boot_config_sequencer_tb;
   // one row: inputs, final stage and mask of stages visited
   typedef struct packed {logic fs; logic sg; logic [1:0] ln; logic m3; logic [2:0] cf; logic pc; logic pd;
      logic lg; logic [1:0] ek; logic [3:0] gp; logic [3:0] es; logic [15:0] mk;} hbcs_row_t;
   logic clk_sys, rst_n, flash_mode_strap, flash_cpol_mode3, nonremovable_strap, charging_enable_strap;
   logic sb_clk_pullup, sb_data_pullup, sb_legacy_mode, soft_disconnect, sig_ok;
   logic flash_byte_valid, sb_write_valid, sb_cmd_valid;
   logic [1:0] flash_lanes, end_kind, flash_lanes_used;
   logic [2:0] config_select_straps;
   logic [3:0] port_disable_plus_straps, port_disable_minus_straps, byte_gap, boot_stage;
   logic [3:0] port_enable_plus, port_enable_minus;
   logic [7:0] otp_cfg, host_cfg, flash_byte, sb_write_reg, merged_cfg;
   logic [15:0] sb_cmd, visited;
   logic [17:0] flash_addr;
   logic flash_read_req, flash_spi_mode3, flash_exec, pll_run, pins_release_n, sb_slave_en;
   logic nonremovable, charging_en, usb_attach_bit, superspeed_enable_bit;
   int err_count, tests_run, cycles, host_cycles, k;
   hbcs_row_t rows [13];
   hbcs_row_t r;
   hbcs_sequencer i_hbcs_sequencer (.*);
   hbcs_partner i_hbcs_partner (.*);
   ////////////////////////////////////////////////////////////////
   // clock and timeout ceiling
   initial
   begin
      clk_sys = 1'b0;
      forever #50 clk_sys = ~clk_sys;
   end
   always @(posedge clk_sys)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         err_count++;
         report_and_stop();
      end
   end
   // stage trace; the fetch address must stay on the signature
   always @(negedge clk_sys)
      if (!rst_n)
      begin
         visited <= 16'h0000;
         host_cycles <= 0;
      end
      else
      begin
         visited[boot_stage] <= 1'b1;
         if (boot_stage === 4'h5) host_cycles <= host_cycles + 1;
         if (flash_read_req === 1'b1) check("flash_addr", hbcs_pkg::SIG_ADDR, flash_addr);
      end
   ////////////////////////////////////////////////////////////////
   task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
      tests_run++;
      if (got !== exp)
      begin
         $display("FAIL %s expected %h seen %h", name, exp, got);
         err_count++;
      end
   endtask
   task automatic report_and_stop();
      $display("compared %0d, mismatched %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // reset for ten cycles, then follow the synchronised release
   task automatic do_reset();
      @(negedge clk_sys);
      rst_n = 1'b0;
      repeat (10) @(negedge clk_sys);
      check("idle", 11'h400, {pins_release_n, pll_run, port_enable_plus, usb_attach_bit, boot_stage});
      rst_n = 1'b1;
      repeat (2) @(posedge clk_sys);
      #1 check("stage_sync", 4'h0, boot_stage);
      @(posedge clk_sys);
      #1 check("stage_probe", 4'h1, boot_stage);
   endtask
   task automatic wait_stage(input logic [3:0] s);
      int n;
      n = 0;
      while (boot_stage !== s && n < 300)
      begin
         @(negedge clk_sys);
         n++;
      end
      check("stage", s, boot_stage);
   endtask
   ////////////////////////////////////////////////////////////////
   initial
   begin
      {rst_n, soft_disconnect, cycles, err_count, tests_run} = '0;
      {flash_mode_strap, sig_ok, flash_lanes, flash_cpol_mode3, config_select_straps} = '0;
      {sb_clk_pullup, sb_data_pullup, sb_legacy_mode, end_kind, byte_gap} = '0;
      {port_disable_plus_straps, port_disable_minus_straps, nonremovable_strap, charging_enable_strap} = '0;
      otp_cfg = 8'hA1;
      host_cfg = 8'h0C;
      rows = '{'{0,0,0,0,0,0,0,0,1,0,8,16'h01CF}, '{1,1,0,0,0,0,0,0,1,0,9,16'h0203},
         '{1,1,1,1,0,0,0,0,1,3,9,16'h0203}, '{1,1,2,0,0,0,0,0,1,1,9,16'h0203},
         '{1,0,3,1,0,0,0,0,1,2,8,16'h01CF}, '{0,0,0,0,1,1,1,0,1,0,8,16'h01FF},
         '{0,0,0,0,2,1,1,0,2,0,8,16'h01FF}, '{0,0,0,0,3,1,1,1,0,0,8,16'h01FF},
         '{0,0,0,0,5,1,0,0,1,0,8,16'h01DF}, '{0,0,0,0,2,0,1,0,1,0,8,16'h01DF},
         '{0,0,0,0,4,1,1,0,1,0,8,16'h01CF}, '{0,0,0,0,6,1,1,0,1,0,8,16'h01CF},
         '{0,0,0,0,7,1,1,0,1,0,8,16'h01CF}};
      for (k = 0; k < 13; k++)
      begin
         r = rows[k];
         {flash_mode_strap, sig_ok, flash_lanes, flash_cpol_mode3, config_select_straps} = {r.fs, r.sg, r.ln, r.m3, r.cf};
         {sb_clk_pullup, sb_data_pullup, sb_legacy_mode, end_kind, byte_gap} = {r.pc, r.pd, r.lg, r.ek, r.gp};
         port_disable_plus_straps = 4'(k);
         port_disable_minus_straps = ~4'(k);
         {nonremovable_strap, charging_enable_strap} = 2'(k);
         do_reset();
         wait_stage(r.es);
         repeat (3) @(negedge clk_sys);
         check("stage_hold", r.es, boot_stage);
         check("run", 2'h2, {pll_run, pins_release_n});
         check("slave", r.mk[5], sb_slave_en);
         check("visited", r.mk, visited);
         if (r.fs) check("lanes", {(r.ln == 2'h3) ? hbcs_pkg::LANES_QUAD : r.ln, r.m3},
            {flash_lanes_used, flash_spi_mode3});
         if (r.es == 4'h9) check("exec", {1'b1, hbcs_pkg::EXEC_ADDR}, {flash_exec, flash_addr});
         else
         begin
            check("attach", 2'h3, {usb_attach_bit, superspeed_enable_bit});
            check("straps", {~4'(k), 4'(k), 2'(k)}, {port_enable_plus, port_enable_minus, nonremovable, charging_en});
            if (r.mk[5]) check("merged", host_cfg | otp_cfg, merged_cfg);
            else check("merged_otp", hbcs_pkg::CFG_RST | otp_cfg, merged_cfg);
            if (r.mk[5]) check("host_wait", 1, host_cycles >= 9);
         end
         $display("row %0d done", k);
      end
      // soft disconnect parks the hub in the connect stage
      soft_disconnect = 1'b1;
      wait_stage(4'h7);
      repeat (5) @(negedge clk_sys);
      check("disc_hold", 6'h07, {usb_attach_bit, superspeed_enable_bit, boot_stage});
      soft_disconnect = 1'b0;
      wait_stage(4'h8);
      check("reattach", 2'h3, {usb_attach_bit, superspeed_enable_bit});
      $display("soft disconnect done");
      // reset dropped during host configuration
      {config_select_straps, sb_clk_pullup, sb_data_pullup} = 5'h07;
      do_reset();
      wait_stage(4'h5);
      rst_n = 1'b0;
      #1 check("abort", 12'h800, {pins_release_n, pll_run, sb_slave_en, port_enable_plus, usb_attach_bit, boot_stage});
      $display("reset abort done");
      report_and_stop();
   end
endmodule
